// ### common/tdmcm_pkg.sv
// tdmcm_pkg: constants for the tdm connection memory and delay block
package tdmcm_pkg;
  // ----------------------------------------------------------------
  // host port map
  // ----------------------------------------------------------------
  localparam logic [12:0] CTRL_ADDR = 13'h0000;
  localparam logic [12:0] MODE_ADDR = 13'h0001;
  localparam logic [12:0] CML_BASE = 13'h0800;
  localparam logic [12:0] CMH_BASE = 13'h1000;
  localparam int CM_WINDOW = 2048;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_VARDLY_BIT = 4;
  localparam int CTRL_BPE_BIT = 3;
  localparam int MODE_START_BIT = 0;
  localparam int MODE_PAT_LSB = 1;
  localparam int CML_LAW_BIT = 15;
  localparam int CML_VAR_BIT = 14;
  localparam int CML_SSA_LSB = 9;
  localparam int CML_SCA_LSB = 1;
  localparam int CML_MSG_LSB = 3;
  localparam int CML_MODE_BIT = 0;
  localparam int CMH_WIDTH = 5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLOCK_PROG_US = 250;
  localparam int BLOCK_PROG_CYC = (BLOCK_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VAR_MIN_CH = 7;
  localparam int CONST_FRAMES = 2;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TDMCM_IDLE = 2'b00,
    TDMCM_FILL = 2'b01,
    TDMCM_HOLD = 2'b10
  } tdmcm_state_t;
endpackage : tdmcm_pkg

// ### src/tdmcm_mem.sv
// tdmcm_mem: single port memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module tdmcm_mem #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 2048,
  parameter int AW = 11
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : tdmcm_mem
`default_nettype wire

// ### src/tdmcm_top.sv
// tdmcm_top: per-channel connection memory, delay control and block fill
`timescale 1ns/1ns
`default_nettype none
module tdmcm_top
  import tdmcm_pkg::*;
#(
  parameter int CHANNELS = 2048,
  parameter int AW = 11,
  parameter int FRAME_CH = 256,
  parameter int FILL_CYCLES = tdmcm_pkg::BLOCK_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host port: one access per strobe, ack next cycle, read data one cycle after the ack
  input wire logic host_cs_i,
  input wire logic host_we_i,
  input wire logic [12:0] host_addr_i,
  input wire logic [15:0] host_wdata_i,
  output logic [15:0] host_rdata_o,
  output logic host_ack_o,
  // switch-side channel lookup
  input wire logic lookup_i,
  input wire logic [AW-1:0] lookup_ch_i,
  output logic lookup_valid_o,
  output logic [4:0] src_stream_o,
  output logic [7:0] src_channel_o,
  output logic variable_delay_o,
  output logic [1:0] delay_frames_o,
  output logic message_mode_o,
  output logic [7:0] message_byte_o,
  output logic law_conv_o,
  output logic [4:0] law_ctrl_o,
  output logic out_valid_o,
  output logic variable_delay_global_enable_o,
  output logic block_busy_o
);
  localparam int W = 16 + CMH_WIDTH;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic vardly_en_r;
  logic bpe_r;
  logic start_r;
  logic [2:0] pat_r;
  tdmcm_state_t state_r;
  logic [AW-1:0] fill_ptr_r;
  logic [31:0] fill_cnt_r;
  logic fill_done;

  logic host_cm;
  logic host_cmh;
  logic host_cml;
  logic [AW-1:0] host_idx;

  assign host_cml = host_addr_i >= CML_BASE && host_addr_i < CML_BASE + 13'(CM_WINDOW);
  assign host_cmh = host_addr_i >= CMH_BASE && host_addr_i < CMH_BASE + 13'(CM_WINDOW);
  assign host_cm = host_cml | host_cmh;
  assign host_idx = host_addr_i[AW-1:0];

  logic wr_ctrl;
  logic wr_mode;
  assign wr_ctrl = host_cs_i && host_we_i && host_addr_i == CTRL_ADDR;
  assign wr_mode = host_cs_i && host_we_i && host_addr_i == MODE_ADDR;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      vardly_en_r <= 1'b0;
      bpe_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      vardly_en_r <= host_wdata_i[CTRL_VARDLY_BIT];
      bpe_r <= host_wdata_i[CTRL_BPE_BIT]; // enable cleared only by software or by reset
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      start_r <= 1'b0;
      pat_r <= 3'h0;
    end
    else if (wr_mode)
    begin
      pat_r <= host_wdata_i[MODE_PAT_LSB +: 3];
      // start only latches while enable is already high
      start_r <= host_wdata_i[MODE_START_BIT] & bpe_r;
    end
    else if (fill_done)
    begin
      start_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // block programming engine
  // ----------------------------------------------------------------
  // the fill walks the memory once but the pass is stretched to the full
  // time so software sees the documented minimum duration
  assign fill_done = state_r == TDMCM_FILL && fill_cnt_r == 32'(FILL_CYCLES - 1);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= TDMCM_IDLE;
      fill_ptr_r <= '0;
      fill_cnt_r <= 32'h0;
    end
    else
    begin
      case (state_r)
        TDMCM_IDLE:
        begin
          fill_ptr_r <= '0;
          fill_cnt_r <= 32'h0;
          if (start_r && bpe_r)
          begin
            state_r <= TDMCM_FILL;
          end
        end
        TDMCM_FILL:
        begin
          if (!start_r || !bpe_r)
          begin
            state_r <= TDMCM_IDLE;
          end
          else if (fill_done)
          begin
            state_r <= TDMCM_HOLD;
          end
          else if (!wr_commit_r)
          begin
            // a host commit owns the memory this cycle; hold the walk so no word is skipped
            fill_cnt_r <= fill_cnt_r + 32'h1;
            if (fill_ptr_r != AW'(CHANNELS - 1))
            begin
              fill_ptr_r <= fill_ptr_r + AW'(1);
            end
          end
        end
        TDMCM_HOLD:
        begin
          // wait for software to drop the enable, or start for a new pass
          if (!bpe_r)
          begin
            state_r <= TDMCM_IDLE;
          end
          else if (start_r)
          begin
            state_r <= TDMCM_IDLE;
          end
        end
        default:
        begin
          state_r <= TDMCM_IDLE;
        end
      endcase
    end
  end

  logic filling;
  assign filling = state_r == TDMCM_FILL && start_r && bpe_r && fill_cnt_r < 32'(CHANNELS);

  // ----------------------------------------------------------------
  // memory port arbitration
  // ----------------------------------------------------------------
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [W-1:0] mem_wdata;
  logic [W-1:0] mem_rdata;
  logic wr_commit_r;
  logic wr_high_r;
  logic [AW-1:0] wr_idx_r;
  logic [15:0] wr_data_r;
  logic [W-1:0] wr_word;

  // host writes to one half keep the other half by read-modify-write; the
  // price is one commit cycle in which the memory refuses the host
  always_comb
  begin
    mem_we = 1'b0;
    mem_addr = lookup_ch_i;
    mem_wdata = '0;
    if (filling)
    begin
      mem_we = 1'b1;
      mem_addr = fill_ptr_r;
      mem_wdata = {5'h0, 13'h0, pat_r};
    end
    else if (host_cs_i && host_cm)
    begin
      mem_addr = host_idx;
    end
  end

  tdmcm_mem #(
    .WIDTH(W),
    .DEPTH(CHANNELS),
    .AW(AW)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we | wr_commit_r),
    .addr_i(wr_commit_r ? wr_idx_r : mem_addr),
    .wdata_i(wr_commit_r ? wr_word : mem_wdata),
    .rdata_o(mem_rdata)
  );

  // host write is read-modify-write: read in cycle 0, write in cycle 1
  always_comb
  begin
    wr_word = mem_rdata;
    if (wr_high_r)
    begin
      wr_word[W-1:16] = wr_data_r[CMH_WIDTH-1:0];
    end
    else
    begin
      wr_word[15:0] = wr_data_r;
    end
  end

  logic rd_pend_r;
  logic rd_high_r;
  logic lk_pend_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_commit_r <= 1'b0;
      wr_high_r <= 1'b0;
      wr_idx_r <= '0;
      wr_data_r <= 16'h0;
      rd_pend_r <= 1'b0;
      rd_high_r <= 1'b0;
      lk_pend_r <= 1'b0;
    end
    else
    begin
      wr_commit_r <= host_cs_i && host_we_i && host_cm && !filling && !wr_commit_r;
      wr_high_r <= host_cmh;
      wr_idx_r <= host_idx;
      wr_data_r <= host_wdata_i;
      rd_pend_r <= host_cs_i && !host_we_i && host_cm && !filling && !wr_commit_r;
      rd_high_r <= host_cmh;
      lk_pend_r <= lookup_i && !filling && !(host_cs_i && host_cm) && !wr_commit_r;
    end
  end

  // ----------------------------------------------------------------
  // host read data and acknowledge
  // ----------------------------------------------------------------
  logic [15:0] reg_rd;
  logic reg_hit;
  always_comb
  begin
    reg_rd = 16'h0;
    reg_hit = 1'b0;
    if (host_addr_i == CTRL_ADDR)
    begin
      reg_hit = 1'b1;
      reg_rd[CTRL_VARDLY_BIT] = vardly_en_r;
      reg_rd[CTRL_BPE_BIT] = bpe_r;
    end
    else if (host_addr_i == MODE_ADDR)
    begin
      reg_hit = 1'b1;
      reg_rd[MODE_START_BIT] = start_r;
      reg_rd[MODE_PAT_LSB +: 3] = pat_r;
    end
  end

  logic reg_rd_pend_r;
  logic [15:0] reg_rd_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_rd_pend_r <= 1'b0;
      reg_rd_r <= 16'h0;
      host_ack_o <= 1'b0;
    end
    else
    begin
      reg_rd_pend_r <= host_cs_i && !host_cm;
      reg_rd_r <= reg_hit ? reg_rd : 16'h0;
      // memory accesses are held off while a fill pass or a write commit owns the memory
      host_ack_o <= host_cs_i && !(host_cm && (filling || wr_commit_r));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      host_rdata_o <= 16'h0;
    end
    else if (rd_pend_r)
    begin
      // unused high-word bits read as zero
      host_rdata_o <= rd_high_r ? {11'h0, mem_rdata[W-1:16]} : mem_rdata[15:0];
    end
    else if (reg_rd_pend_r)
    begin
      host_rdata_o <= reg_rd_r;
    end
  end

  // ----------------------------------------------------------------
  // channel decode toward the switch
  // ----------------------------------------------------------------
  logic [15:0] lw;
  logic [4:0] hw;
  logic [AW-1:0] lookup_ch_r;
  assign lw = mem_rdata[15:0];
  assign hw = mem_rdata[W-1:16];

  // frames of delay for a variable-delay channel given n-m in channels
  function automatic logic [1:0] var_frames(input logic [7:0] m, input logic [7:0] n,
                                            input logic [4:0] si, input logic [4:0] so);
    logic signed [9:0] d;
    d = $signed({2'b00, n}) - $signed({2'b00, m});
    if (d <= 0)
      var_frames = 2'd1;
    else if (d < 10'sd7)
      var_frames = 2'd1;
    else if (d == 10'sd7)
      var_frames = (so < si) ? 2'd1 : 2'd0;
    else
      var_frames = 2'd0;
  endfunction : var_frames

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lookup_valid_o <= 1'b0;
      src_stream_o <= 5'h0;
      src_channel_o <= 8'h0;
      variable_delay_o <= 1'b0;
      delay_frames_o <= 2'd0;
      message_mode_o <= 1'b0;
      message_byte_o <= 8'h0;
      law_conv_o <= 1'b0;
      law_ctrl_o <= 5'h0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      lookup_valid_o <= lk_pend_r;
      if (lk_pend_r)
      begin
        message_mode_o <= lw[CML_MODE_BIT];
        src_channel_o <= lw[CML_SCA_LSB +: 8];
        src_stream_o <= lw[CML_SSA_LSB +: 5];
        message_byte_o <= lw[CML_MSG_LSB +: 8];
        // law conversion holds in any mode when enabled
        law_conv_o <= lw[CML_LAW_BIT];
        law_ctrl_o <= lw[CML_LAW_BIT] ? hw : 5'h0;
        variable_delay_o <= !lw[CML_MODE_BIT] && lw[CML_VAR_BIT];
        if (!lw[CML_MODE_BIT] && lw[CML_VAR_BIT])
        begin
          delay_frames_o <= var_frames(lw[CML_SCA_LSB +: 8], 8'(lookup_ch_r),
                                       lw[CML_SSA_LSB +: 5], 5'(lookup_ch_r >> 8));
          out_valid_o <= vardly_en_r;
        end
        else
        begin
          delay_frames_o <= 2'(CONST_FRAMES);
          out_valid_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lookup_ch_r <= '0;
      variable_delay_global_enable_o <= 1'b0;
      block_busy_o <= 1'b0;
    end
    else
    begin
      lookup_ch_r <= lookup_ch_i;
      variable_delay_global_enable_o <= vardly_en_r;
      block_busy_o <= state_r == TDMCM_FILL;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // pass length counted apart from the engine's own counter
  logic [31:0] fill_len_r;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || state_r != TDMCM_FILL)
    begin
      fill_len_r <= 32'h0;
    end
    else
    begin
      fill_len_r <= fill_len_r + 32'h1;
    end
  end

  a_start_needs_en: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(start_r) |-> $past(bpe_r)) else $error("start latched without enable");
  a_abort_fill: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == TDMCM_FILL && !bpe_r) |=> state_r == TDMCM_IDLE) else $error("no abort");
  a_done_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    fill_done && !wr_mode |=> !start_r) else $error("start not cleared");
  a_fill_pattern: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    filling |-> mem_we && mem_wdata == {18'h0, pat_r}) else $error("bad fill word");
  a_fill_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(state_r == TDMCM_HOLD) |-> fill_len_r >= 32'(FILL_CYCLES)) else $error("short pass");
  a_law_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lookup_valid_o && !law_conv_o |-> law_ctrl_o == 5'h0) else $error("high word leaked");
  a_const_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lookup_valid_o && !variable_delay_o |-> delay_frames_o == 2'd2) else $error("const");
  a_mode_var: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    lookup_valid_o && message_mode_o |-> !variable_delay_o) else $error("msg with var");
  c_fill_done: cover property (@(posedge clk_i) fill_done);
  c_var_lookup: cover property (@(posedge clk_i) lookup_valid_o && variable_delay_o);
  c_msg_lookup: cover property (@(posedge clk_i) lookup_valid_o && message_mode_o);
endmodule : tdmcm_top
`default_nettype wire

// ### testbench/tdmcm_host.sv
// tdmcm_host: host processor model on the parallel port
`timescale 1ns/1ns
`default_nettype none
module tdmcm_host (
  input wire logic clk_i,
  output logic cs_o,
  output logic we_o,
  output logic [12:0] addr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i,
  input wire logic ack_i
);
  initial
  begin
    cs_o = 1'b0;
    we_o = 1'b0;
    addr_o = 13'h1fff;
    wdata_o = 16'h0000;
  end
  // one strobe cycle; a refused access returns ok low and the caller retries
  task automatic xfer(input logic we, input logic [12:0] a, input logic [15:0] d,
    output logic ok, output logic [15:0] q);
    @(posedge clk_i);
    cs_o <= 1'b1;
    we_o <= we;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    cs_o <= 1'b0;
    // released lines flip so a stale value cannot pass for a live one
    addr_o <= ~a;
    wdata_o <= ~d;
    @(negedge clk_i);
    ok = ack_i;
    // second wait also leaves the cycle after the commit cycle of a memory write idle
    @(negedge clk_i);
    q = rdata_i;
  endtask : xfer
endmodule : tdmcm_host
`default_nettype wire

// ### testbench/tdmcm_tb_top.sv
// tdmcm_tb_top: self-checking bench for the connection memory block
`timescale 1ns/1ns
`default_nettype none
module tdmcm_tb_top;
  import tdmcm_pkg::*;
  localparam int FILL = 4100;
  logic clk_i, sys_rst_i, cs, we, ack, lk_i, lk_v, vd, mm, lc, out_v, gen, busy;
  logic [12:0] addr;
  logic [15:0] wd, rd, q;
  logic [10:0] lk_ch;
  logic [4:0] sst, lctl;
  logic [7:0] sch, msg;
  logic [1:0] dfr;
  int failures = 0;
  int n_checks = 0;
  int k, cnt;
  int cm[6] = '{9, 2, 2, 1, 1, 20};
  int cn[6] = '{5, 9, 9, 4, 20, 1};
  int cs5[6] = '{3, 4, 1, 3, 3, 3};
  int cv[6] = '{1, 1, 1, 1, 1, 0};
  tdmcm_top #(.FILL_CYCLES(FILL)) tdmcm_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .host_cs_i(cs), .host_we_i(we), .host_addr_i(addr), .host_wdata_i(wd),
    .host_rdata_o(rd), .host_ack_o(ack), .lookup_i(lk_i), .lookup_ch_i(lk_ch),
    .lookup_valid_o(lk_v), .src_stream_o(sst), .src_channel_o(sch),
    .variable_delay_o(vd), .delay_frames_o(dfr), .message_mode_o(mm),
    .message_byte_o(msg), .law_conv_o(lc), .law_ctrl_o(lctl), .out_valid_o(out_v),
    .variable_delay_global_enable_o(gen), .block_busy_o(busy));
  tdmcm_host tdmcm_host_i (.clk_i(clk_i), .cs_o(cs), .we_o(we), .addr_o(addr),
    .wdata_o(wd), .rdata_i(rd), .ack_i(ack));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // retries refused accesses a bounded number of times
  task automatic acc(input logic w, input logic [12:0] a, input logic [15:0] d);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 8 && ok !== 1'b1; i++)
      tdmcm_host_i.xfer(w, a, d, ok, q);
    if (ok !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
  endtask : acc
  task automatic lookup(input logic [10:0] ch);
    @(posedge clk_i);
    lk_i <= 1'b1;
    lk_ch <= ch;
    @(posedge clk_i);
    lk_i <= 1'b0;
    for (int i = 0; i < 4 && lk_v !== 1'b1; i++)
      @(negedge clk_i);
    chk("lookup_valid", 16'(lk_v), 16'h0001);
    if (lk_v !== 1'b1)
      wrap_up();
  endtask : lookup
  task automatic wait_idle(input int lim);
    cnt = 0;
    while (busy === 1'b1 && cnt < lim)
    begin
      @(negedge clk_i);
      cnt++;
    end
    if (busy === 1'b1)
    begin
      failures++;
      wrap_up();
    end
  endtask : wait_idle
  function automatic logic [1:0] frames(input int v, n, m, so, si);
    if (v == 0)
      return 2'h2;
    if (n - m < 7)
      return 2'h1;
    if (n - m == 7)
      return (so < si) ? 2'h1 : 2'h0;
    return 2'h0;
  endfunction : frames
  initial
  begin
    sys_rst_i = 1'b1;
    lk_i = 1'b0;
    lk_ch = 11'h000;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk("busy_rst", 16'(busy), 16'h0000);
    chk("lk_v_rst", 16'(lk_v), 16'h0000);
    acc(1'b1, CTRL_ADDR, 16'h0010);
    chk("vardly_en", 16'(gen), 16'h0001);
    acc(1'b1, CML_BASE + 13'h0011, 16'hbfff);
    acc(1'b0, CML_BASE + 13'h0011, 16'h0000);
    chk("low_rw", q, 16'hbfff);
    acc(1'b1, CMH_BASE + 13'h0011, 16'h001f);
    acc(1'b0, CMH_BASE + 13'h0011, 16'h0000);
    chk("high_rw", q, 16'h001f);
    acc(1'b0, 13'h0002, 16'h0000);
    chk("unmapped", q, 16'h0000);
    $display("test port done");
    for (k = 0; k < 6; k++)
    begin
      acc(1'b1, CMH_BASE + 13'h0200 + 13'(cn[k]), 16'(k + 1));
      acc(1'b1, CML_BASE + 13'h0200 + 13'(cn[k]), {k[0], cv[k][0], 5'(cs5[k]),
        8'(cm[k]), 1'b0});
      lookup(11'h200 + 11'(cn[k]));
      chk("src_stream", 16'(sst), 16'(cs5[k]));
      chk("src_channel", 16'(sch), 16'(cm[k]));
      chk("var_delay", 16'(vd), 16'(cv[k]));
      chk("out_valid", 16'(out_v), 16'h0001);
      chk("frames", 16'(dfr), 16'(frames(cv[k], cn[k], cm[k], 2, cs5[k])));
      chk("law_conv", 16'(lc), 16'(k[0]));
      if (k[0])
        chk("law_ctrl", 16'(lctl), 16'(k + 1));
    end
    $display("test delay done");
    acc(1'b1, CML_BASE + 13'h0205, 16'h8529);
    lookup(11'h205);
    chk("msg_mode", 16'(mm), 16'h0001);
    chk("msg_byte", 16'(msg), 16'h00a5);
    chk("msg_law", 16'(lc), 16'h0001);
    chk("msg_law_ctrl", 16'(lctl), 16'h0001);
    acc(1'b1, CTRL_ADDR, 16'h0000);
    chk("vardly_off", 16'(gen), 16'h0000);
    lookup(11'h209);
    chk("out_invalid", 16'(out_v), 16'h0000);
    acc(1'b1, 13'h0001, 16'h000f);
    acc(1'b0, 13'h0001, 16'h0000);
    chk("start_bit_ignored", q & 16'h0001, 16'h0000);
    chk("start_ignored", 16'(busy), 16'h0000);
    acc(1'b0, CML_BASE + 13'h0205, 16'h0000);
    chk("untouched", q, 16'h8529);
    $display("test message done");
    acc(1'b1, CTRL_ADDR, 16'h0008);
    acc(1'b1, 13'h0001, 16'h000b);
    @(negedge clk_i);
    chk("busy", 16'(busy), 16'h0001);
    wait_idle(FILL + 50);
    chk("pass_long", 16'(cnt >= FILL - 4), 16'h0001);
    chk("pass_end", 16'(busy), 16'h0000);
    acc(1'b0, 13'h0001, 16'h0000);
    chk("start_clr", q & 16'h0001, 16'h0000);
    acc(1'b0, CTRL_ADDR, 16'h0000);
    chk("enable_kept", q & 16'h0008, 16'h0008);
    acc(1'b0, CML_BASE + 13'h0205, 16'h0000);
    chk("fill_low", q, 16'h0005);
    acc(1'b0, CMH_BASE + 13'h0205, 16'h0000);
    chk("fill_high", q, 16'h0000);
    acc(1'b1, 13'h0001, 16'h0003);
    acc(1'b1, 13'h0001, 16'h0000);
    chk("abort_start_began", 16'(busy), 16'h0001);
    wait_idle(4);
    chk("abort_start", 16'(busy), 16'h0000);
    acc(1'b1, 13'h0001, 16'h0003);
    acc(1'b1, CTRL_ADDR, 16'h0000);
    chk("abort_enable_began", 16'(busy), 16'h0001);
    wait_idle(4);
    chk("abort_enable", 16'(busy), 16'h0000);
    acc(1'b1, 13'h0001, 16'h0000);
    $display("test fill done");
    wrap_up();
  end
endmodule : tdmcm_tb_top
`default_nettype wire
